//--- core/sbp_field_merge.sv
// inserts an aligned field into a fill mask byte
`timescale 1ns/100ps
`default_nettype none
module sbp_field_merge
    import sbp_pkg::*;
(
    input  wire logic [7:0] fill_mask_byte,
    input  wire logic [7:0] field_bits,
    input  wire logic [2:0] field_bit_count,
    input  wire logic [2:0] start_pos,
    output logic [7:0]      merged_byte
);
    logic [15:0] wide_sel;
    logic [7:0]  sel;
    logic [15:0] wide_data;

    // count zero means a whole byte of eight bits
    always_comb begin
        wide_sel  = (field_bit_count == 3'h0) ? 16'h00FF
                    : (16'h0001 << field_bit_count) - 16'h0001;
        wide_sel  = wide_sel << start_pos;
        sel       = wide_sel[7:0];
        wide_data = {8'h00, field_bits} << start_pos;
        // field bits win over mask bits inside the field
        merged_byte = (wide_data[7:0] & sel) | (fill_mask_byte & ~sel);
    end
endmodule : sbp_field_merge
`default_nettype wire

//--- core/sbp_fifo.sv
// synchronous valid/ready fifo for channel data
`timescale 1ns/100ps
`default_nettype none
module sbp_fifo
    import sbp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    // pointers need a power of two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("sbp_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             push;
    logic             pop;

    // extra pointer bit separates full from empty
    assign out_valid = (wr_ptr_reg != rd_ptr_reg);
    assign in_ready  = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
                       || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    // storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule : sbp_fifo
`default_nettype wire

//--- core/sbp_pkg.sv
// constants for the subchannel bit field processor
`default_nettype none
package sbp_pkg;
    // clock and frame timing
    localparam int SYS_CLK_HZ        = 20_000_000;
    localparam int FRAME_PERIOD_NS   = 125_000;
    localparam int FRAME_CYCLES      = (SYS_CLK_HZ / 1_000_000) * FRAME_PERIOD_NS / 1_000;
    // register byte offsets
    localparam logic [3:0] ADDR_TX_CFG   = 4'h0;
    localparam logic [3:0] ADDR_TX_CTRL  = 4'h1;
    localparam logic [3:0] ADDR_RX_CFG   = 4'h2;
    localparam logic [3:0] ADDR_RX_CTRL  = 4'h3;
    localparam logic [3:0] ADDR_ARR_SEL  = 4'h4;
    localparam logic [3:0] ADDR_MASK     = 4'h5;
    localparam logic [3:0] ADDR_STATUS   = 4'h6;
    localparam logic [3:0] ADDR_RX_LAST  = 4'h7;
    // subchannel_config_entry field positions
    localparam int CFG_CNT_LSB   = 0;
    localparam int CFG_START_LSB = 3;
    localparam int CFG_INV_BIT   = 6;
    localparam int CFG_LOOP_BIT  = 7;
    // framing_control_entry field positions
    localparam int CTL_BYPASS_BIT = 0;
    localparam int CTL_IFF_BIT    = 1;
    localparam int CTL_EN_BIT     = 2;
    // array selection field positions
    localparam int SEL_DIR_BIT    = 0;
    localparam int SEL_CH_LSB     = 1;
    // status bit positions
    localparam int ST_TX_EMPTY    = 0;
    localparam int ST_RX_FULL     = 1;
    localparam int ST_RX_OVF      = 2;
    localparam int ST_TX_IDLE     = 3;
    // reset values
    localparam logic [7:0] CFG_RESET  = 8'h00;
    localparam logic [7:0] CTL_RESET  = 8'h01;
    localparam logic [7:0] SEL_RESET  = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    // fill patterns
    localparam logic [7:0] FLAG_FILL  = 8'h7E;
    localparam logic [7:0] ONES_FILL  = 8'hFF;
    localparam logic [3:0] BYTE_BITS  = 4'h8;
    // sequencer states
    typedef enum logic [2:0] {
        SBP_IDLE    = 3'b000,
        SBP_TX_BYTE = 3'b001,
        SBP_TX_BITS = 3'b010,
        SBP_RX_BYTE = 3'b011,
        SBP_RX_BITS = 3'b100
    } sbp_state_e;
endpackage : sbp_pkg
`default_nettype wire

//--- core/sbp_subchannel.sv
// subchannel bit field processor for one channel, both directions
`timescale 1ns/100ps
`default_nettype none
module sbp_subchannel
    import sbp_pkg::*;
#(
    parameter int FIFO_DEPTH   = 16,
    parameter int FRAME_LENGTH = FRAME_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // transmit data from the host side
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // receive data to the host side
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    // line side, one byte each way per frame
    output logic [7:0]      line_tx_byte,
    input  wire logic [7:0] line_rx_byte,
    output logic            frame_tick,
    output logic [7:0]      chan_rx_byte
);
    if (FRAME_LENGTH < 32) begin : g_frame_check
        $error("frame length too short for bit sequencing");
    end

    localparam int FCW = $clog2(FRAME_LENGTH);

    // registers
    logic [7:0]  tx_cfg_reg;
    logic [7:0]  tx_ctrl_reg;
    logic [7:0]  rx_cfg_reg;
    logic [7:0]  rx_ctrl_reg;
    logic [7:0]  arr_sel_reg;
    logic [7:0]  tx_mask_reg;
    logic [7:0]  rx_mask_reg;
    logic        rx_ovf_reg;
    logic        tx_idle_reg;
    logic [7:0]  rx_last_reg;
    logic [FCW-1:0] frame_cnt_reg;
    // sequencer
    sbp_state_e  state_reg;
    logic [7:0]  tx_field_reg;
    logic [7:0]  tx_built_reg;
    logic [7:0]  tx_shift_reg;
    logic [3:0]  tx_left_reg;
    logic [3:0]  bit_idx_reg;
    logic [7:0]  rx_acc_reg;
    logic [3:0]  rx_fill_reg;
    logic [7:0]  line_tx_reg;
    logic [7:0]  chan_rx_reg;
    // fifo wires
    logic [7:0]  txq_data;
    logic        txq_valid;
    logic        txq_pop;
    logic [7:0]  rxq_data;
    logic        rxq_push;
    logic        rxq_ready;
    logic [7:0]  merged_byte;
    // decoded fields
    logic [2:0]  tx_cnt;
    logic [2:0]  tx_start;
    logic [2:0]  rx_cnt;
    logic [2:0]  rx_start;
    logic [3:0]  tx_cnt_eff;
    logic [3:0]  rx_cnt_eff;
    logic        tx_bypass;
    logic        rx_bypass;
    logic        tx_en;
    logic        rx_en;
    logic        tx_inv;
    logic        rx_inv;
    logic        loop_en;
    logic [7:0]  rx_aligned;
    logic [7:0]  idle_byte;
    logic        rx_bit;
    logic        sel_dir;
    logic        status_rd;

    assign tx_cnt     = tx_cfg_reg[CFG_CNT_LSB +: 3];
    assign tx_start   = tx_cfg_reg[CFG_START_LSB +: 3];
    assign rx_cnt     = rx_cfg_reg[CFG_CNT_LSB +: 3];
    assign rx_start   = rx_cfg_reg[CFG_START_LSB +: 3];
    assign tx_inv     = tx_cfg_reg[CFG_INV_BIT];
    assign rx_inv     = rx_cfg_reg[CFG_INV_BIT];
    assign loop_en    = tx_cfg_reg[CFG_LOOP_BIT];
    assign tx_bypass  = tx_ctrl_reg[CTL_BYPASS_BIT];
    assign rx_bypass  = rx_ctrl_reg[CTL_BYPASS_BIT];
    assign tx_en      = tx_ctrl_reg[CTL_EN_BIT];
    assign rx_en      = rx_ctrl_reg[CTL_EN_BIT];
    assign sel_dir    = arr_sel_reg[SEL_DIR_BIT];
    // zero count stands for a full byte
    assign tx_cnt_eff = (tx_cnt == 3'h0) ? BYTE_BITS : {1'b0, tx_cnt};
    assign rx_cnt_eff = (rx_cnt == 3'h0) ? BYTE_BITS : {1'b0, rx_cnt};
    // field moved down to bit 0, upper bits left unmasked
    assign rx_aligned = chan_rx_reg >> rx_start;
    assign rx_bit     = rx_aligned[bit_idx_reg[2:0]] ^ rx_inv;
    // empty queue fill: flag pattern unless ones selected
    assign idle_byte  = tx_ctrl_reg[CTL_IFF_BIT] ? ONES_FILL : FLAG_FILL;
    assign status_rd  = reg_rd && (reg_addr == ADDR_STATUS);

    // frame divider, one-cycle tick every frame period
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            frame_cnt_reg <= '0;
        end else if (frame_cnt_reg == FCW'(FRAME_LENGTH - 1)) begin
            frame_cnt_reg <= '0;
        end else begin
            frame_cnt_reg <= frame_cnt_reg + 1'b1;
        end
    end
    assign frame_tick = (frame_cnt_reg == FCW'(FRAME_LENGTH - 1));

    // register writes; mask entry goes to the selected direction
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_cfg_reg  <= CFG_RESET;
            tx_ctrl_reg <= CTL_RESET;
            rx_cfg_reg  <= CFG_RESET;
            rx_ctrl_reg <= CTL_RESET;
            arr_sel_reg <= SEL_RESET;
            tx_mask_reg <= MASK_RESET;
            rx_mask_reg <= MASK_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_TX_CFG:  tx_cfg_reg  <= reg_wdata;
                ADDR_TX_CTRL: tx_ctrl_reg <= reg_wdata;
                ADDR_RX_CFG:  rx_cfg_reg  <= reg_wdata;
                ADDR_RX_CTRL: rx_ctrl_reg <= reg_wdata;
                ADDR_ARR_SEL: arr_sel_reg <= reg_wdata;
                ADDR_MASK: begin
                    if (sel_dir) begin
                        rx_mask_reg <= reg_wdata;
                    end else begin
                        tx_mask_reg <= reg_wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_TX_CFG:  reg_rdata <= tx_cfg_reg;
                ADDR_TX_CTRL: reg_rdata <= tx_ctrl_reg;
                ADDR_RX_CFG:  reg_rdata <= rx_cfg_reg;
                ADDR_RX_CTRL: reg_rdata <= rx_ctrl_reg;
                ADDR_ARR_SEL: reg_rdata <= arr_sel_reg;
                ADDR_MASK:    reg_rdata <= sel_dir ? rx_mask_reg : tx_mask_reg;
                ADDR_STATUS:  reg_rdata <= {4'h0, tx_idle_reg, rx_ovf_reg,
                                            ~rxq_ready, ~txq_valid};
                ADDR_RX_LAST: reg_rdata <= rx_last_reg;
                default:      reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // line exchange once per frame; receive byte kept as delivered, or the built transmit byte when loop_en is set
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            line_tx_reg <= MASK_RESET;
            chan_rx_reg <= 8'h00;
        end else if (frame_tick) begin
            line_tx_reg <= tx_built_reg;
            chan_rx_reg <= loop_en ? tx_built_reg : line_rx_byte;
        end
    end
    assign line_tx_byte = line_tx_reg;
    assign chan_rx_byte = chan_rx_reg;

    // sequencer: transmit build then receive extract, well inside a frame
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= SBP_IDLE;
        end else begin
            unique case (state_reg)
                SBP_IDLE: begin
                    if (frame_tick) begin
                        state_reg <= tx_bypass ? SBP_TX_BYTE : SBP_TX_BITS;
                    end
                end
                SBP_TX_BYTE: state_reg <= rx_bypass ? SBP_RX_BYTE : SBP_RX_BITS;
                SBP_TX_BITS: begin
                    if (bit_idx_reg == tx_cnt_eff) begin
                        state_reg <= rx_bypass ? SBP_RX_BYTE : SBP_RX_BITS;
                    end
                end
                SBP_RX_BYTE: state_reg <= SBP_IDLE;
                SBP_RX_BITS: begin
                    if (bit_idx_reg == rx_cnt_eff - 4'h1) begin
                        state_reg <= SBP_IDLE;
                    end
                end
                default: state_reg <= SBP_IDLE;
            endcase
        end
    end

    // bit index runs over one field at a time
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bit_idx_reg <= 4'h0;
        end else if (state_reg == SBP_TX_BITS) begin
            if (bit_idx_reg == tx_cnt_eff) begin
                bit_idx_reg <= 4'h0;
            end else if (tx_left_reg != 4'h0) begin
                bit_idx_reg <= bit_idx_reg + 4'h1;
            end
        end else if (state_reg == SBP_RX_BITS) begin
            bit_idx_reg <= bit_idx_reg + 4'h1;
        end else begin
            bit_idx_reg <= 4'h0;
        end
    end

    // framed transmit bit source: one fifo byte feeds several fields
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_shift_reg <= 8'h00;
            tx_left_reg  <= 4'h0;
            tx_field_reg <= 8'h00;
            tx_idle_reg  <= 1'b1;
        end else if (state_reg == SBP_IDLE && frame_tick) begin
            tx_field_reg <= 8'h00;
        end else if (state_reg == SBP_TX_BITS && bit_idx_reg != tx_cnt_eff) begin
            if (tx_left_reg == 4'h0) begin
                // refill from the queue, or idle pattern when it is empty
                tx_shift_reg <= (txq_valid && tx_en) ? txq_data : idle_byte;
                tx_idle_reg  <= !(txq_valid && tx_en);
                tx_left_reg  <= BYTE_BITS;
            end else begin
                // lowest bit first into the next field position
                tx_field_reg[bit_idx_reg[2:0]] <= tx_shift_reg[0] ^ tx_inv;
                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                tx_left_reg  <= tx_left_reg - 4'h1;
            end
        end else if (state_reg == SBP_TX_BYTE) begin
            tx_field_reg <= (txq_valid && tx_en) ? (txq_data ^ {8{tx_inv}}) : idle_byte;
            tx_idle_reg  <= !(txq_valid && tx_en);
        end
    end

    // transparent pops a byte a frame, framed pops on refill
    assign txq_pop = tx_en && txq_valid
                     && ((state_reg == SBP_TX_BYTE)
                         || (state_reg == SBP_TX_BITS && tx_left_reg == 4'h0
                             && bit_idx_reg != tx_cnt_eff));

    // merge the finished field into the fill mask
    sbp_field_merge u_merge (
        .fill_mask_byte  (tx_mask_reg),
        .field_bits      (tx_field_reg),
        .field_bit_count (tx_cnt),
        .start_pos       (tx_start),
        .merged_byte     (merged_byte)
    );

    // built byte is held until the next frame tick sends it
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_built_reg <= MASK_RESET;
        end else if ((state_reg == SBP_TX_BYTE) ||
                     (state_reg == SBP_RX_BYTE) || (state_reg == SBP_RX_BITS)) begin
            tx_built_reg <= merged_byte;
        end
    end

    // framed receive: one field bit a cycle, assembled lowest bit first
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_acc_reg  <= 8'h00;
            rx_fill_reg <= 4'h0;
        end else if (state_reg == SBP_RX_BITS && rx_en) begin
            rx_acc_reg <= {rx_bit, rx_acc_reg[7:1]};
            if (rx_fill_reg == BYTE_BITS - 4'h1) begin
                rx_fill_reg <= 4'h0;
            end else begin
                rx_fill_reg <= rx_fill_reg + 4'h1;
            end
        end
    end

    // push whole bytes; transparent hands over the aligned byte
    assign rxq_push = rx_en && ((state_reg == SBP_RX_BYTE) ||
                      (state_reg == SBP_RX_BITS && rx_fill_reg == BYTE_BITS - 4'h1));
    assign rxq_data = (state_reg == SBP_RX_BYTE) ? (rx_aligned ^ {8{rx_inv}})
                                                 : {rx_bit, rx_acc_reg[7:1]};

    // last byte handed on, and overflow where the queue had no room
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_last_reg <= 8'h00;
        end else if (rxq_push) begin
            rx_last_reg <= rxq_data;
        end
    end

    // overflow is sticky; a new loss beats the clear by status read
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_ovf_reg <= 1'b0;
        end else if (rxq_push && !rxq_ready) begin
            rx_ovf_reg <= 1'b1;
        end else if (status_rd) begin
            rx_ovf_reg <= 1'b0;
        end
    end

    // host side queues; a full transmit queue stalls the source
    sbp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (txq_data),
        .out_valid (txq_valid),
        .out_ready (txq_pop)
    );

    sbp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_data   (rxq_data),
        .in_valid  (rxq_push),
        .in_ready  (rxq_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );
endmodule : sbp_subchannel
`default_nettype wire

//--- test/sbp_line_model.sv
// line side model: one byte each way per frame
`timescale 1ns/100ps
`default_nettype none
module sbp_line_model (
    input  wire logic       clk_sys,
    input  wire logic       frame_tick,
    input  wire logic [7:0] line_tx_byte,
    output logic [7:0]      line_rx_byte
);
    logic [7:0] feed_q[$];
    logic [7:0] sent_q[$];
    logic [7:0] idle_byte = 8'h00;
    logic       tick_d    = 1'b0;
    initial line_rx_byte = 8'h00;
    // next byte goes out just after the tick that sampled the old one
    always @(posedge clk_sys) begin
        tick_d <= frame_tick;
        if (frame_tick && feed_q.size() > 0) line_rx_byte <= feed_q.pop_front();
        else if (frame_tick) line_rx_byte <= idle_byte;
        if (tick_d) sent_q.push_back(line_tx_byte);
    end
endmodule : sbp_line_model
`default_nettype wire

//--- test/sbp_subchannel_assertions.sv
// port level assertions for the subchannel processor
`timescale 1ns/100ps
`default_nettype none
module sbp_subchannel_checker
    import sbp_pkg::*;
#(
    parameter int FRAME_LENGTH = FRAME_CYCLES
) (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] line_tx_byte,
    input wire logic [7:0] line_rx_byte,
    input wire logic       frame_tick,
    input wire logic [7:0] chan_rx_byte
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    logic [15:0] gap_reg;
    logic        seen_reg;
    // cycles since the last tick; first period only bounded, its start is the reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst || frame_tick) gap_reg <= 16'h0000;
        else gap_reg <= gap_reg + 16'h0001;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) seen_reg <= 1'b0;
        else if (frame_tick) seen_reg <= 1'b1;
    end
    sequence cfg_write_s;
        reg_wr && reg_addr == ADDR_TX_CFG;
    endsequence
    sequence cfg_read_s;
        reg_rd && reg_addr == ADDR_TX_CFG;
    endsequence
    frame_period_a: assert property (seen_reg && frame_tick |-> gap_reg == FRAME_LENGTH - 1)
        else $error("frame tick period wrong");
    frame_gap_a: assert property (gap_reg < FRAME_LENGTH)
        else $error("frame tick missing");
    line_hold_a: assert property (!frame_tick |=> $stable(line_tx_byte))
        else $error("line byte changed between ticks");
    chan_copy_a: assert property (frame_tick |=> chan_rx_byte == $past(line_rx_byte))
        else $error("channel byte not forwarded unchanged");
    chan_hold_a: assert property (!frame_tick |=> $stable(chan_rx_byte))
        else $error("channel byte changed between ticks");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read answer");
    unmapped_read_a: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cfg_echo_a: assert property (cfg_write_s ##2 cfg_read_s |=> reg_rdata == $past(reg_wdata, 3))
        else $error("config readback wrong");
    rx_hold_a: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("rx head lost while stalled");
    reset_out_a: assert property (disable iff (1'b0) sys_rst |=> line_tx_byte == 8'hFF
        && chan_rx_byte == 8'h00 && !rx_valid && tx_ready)
        else $error("reset outputs wrong");
endmodule : sbp_subchannel_checker
bind sbp_subchannel sbp_subchannel_checker #(.FRAME_LENGTH(FRAME_LENGTH)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .line_tx_byte(line_tx_byte), .line_rx_byte(line_rx_byte),
    .frame_tick(frame_tick), .chan_rx_byte(chan_rx_byte)
);
`default_nettype wire

//--- test/tb_top.sv
// bench for the subchannel processor: registers, queues, both modes
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import sbp_pkg::*;
;
    localparam int          FL     = 64; // short frame keeps the run brief
    localparam logic [17:0] STREAM = 18'h23CA5; // two bytes then flag fill, lowest bit first
    logic       clk_sys, sys_rst, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid, rx_ready;
    logic       frame_tick;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data, line_tx_byte, line_rx_byte;
    logic [7:0] chan_rx_byte;
    logic [7:0] got[$];
    int         n_errors = 0;
    int         n_tests  = 0;

    sbp_subchannel #(.FIFO_DEPTH(16), .FRAME_LENGTH(FL)) u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .line_tx_byte(line_tx_byte), .line_rx_byte(line_rx_byte),
        .frame_tick(frame_tick), .chan_rx_byte(chan_rx_byte)
    );
    sbp_line_model u_line (
        .clk_sys(clk_sys), .frame_tick(frame_tick), .line_tx_byte(line_tx_byte),
        .line_rx_byte(line_rx_byte)
    );
    // 50 ns period
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    // a gap cycle after each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic ticks(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            do begin
                @(posedge clk_sys);
                k++;
            end while (frame_tick !== 1'b1 && k < 2 * FL);
            if (k >= 2 * FL) begin
                n_errors++;
                conclude();
            end
        end
    endtask : ticks
    // enable well after a tick, past the build window, so the next frame is the first
    task automatic arm(input logic [3:0] a, input logic [7:0] d);
        ticks(1);
        repeat (40) @(posedge clk_sys);
        wr(a, d);
        u_line.sent_q.delete();
    endtask : arm
    task automatic drain();
        got.delete();
        rx_ready <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_sys);
            if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
        end
        rx_ready <= 1'b0;
        check("rx queue empty", 8'h00, {7'h00, rx_valid});
    endtask : drain
    task automatic t_regs();
        logic [7:0] v;
        logic [7:0] tab[6] = '{CFG_RESET, CTL_RESET, CFG_RESET, CTL_RESET, SEL_RESET, MASK_RESET};
        for (int i = 0; i < 6; i++) begin
            rd(4'(i), v);
            check("reset value", tab[i], v);
        end
        wr(4'hC, 8'h5A);
        rd(4'hC, v);
        check("unmapped read", 8'h00, v);
        wr(ADDR_TX_CFG, 8'h2D);
        rd(ADDR_TX_CFG, v);
        check("config readback", 8'h2D, v);
    endtask : t_regs
    // fill the tx queue until refused, then drain it one byte per frame
    task automatic t_tx_plain();
        logic [7:0] v;
        tx_valid <= 1'b1;
        tx_data  <= 8'h01;
        for (int k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (tx_ready === 1'b1) tx_data <= tx_data + 8'h01;
        end
        tx_valid <= 1'b0;
        check("tx queue depth", 8'h10, tx_data - 8'h01);
        wr(ADDR_ARR_SEL, 8'h00);
        wr(ADDR_MASK, 8'hBE);
        wr(ADDR_TX_CFG, 8'h0B);
        arm(ADDR_TX_CTRL, 8'h05);
        ticks(17);
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 16; i++) begin
            v = 8'hBE & 8'hF1 | 8'(((i + 1) % 8) << 1);
            check("plain tx byte", v, u_line.sent_q[i + 1]);
        end
        rd(ADDR_STATUS, v);
        check("tx empty flag", 8'h01, v & 8'h01);
        wr(ADDR_TX_CTRL, 8'h01);
    endtask : t_tx_plain
    task automatic t_tx_framed();
        logic [7:0] v;
        wr(ADDR_MASK, 8'hB3);
        wr(ADDR_TX_CFG, 8'h1B);
        tx_valid <= 1'b1;
        tx_data  <= 8'hA5;
        @(posedge clk_sys);
        tx_data <= 8'h3C;
        @(posedge clk_sys);
        tx_valid <= 1'b0;
        arm(ADDR_TX_CTRL, 8'h04);
        ticks(7);
        repeat (2) @(posedge clk_sys);
        for (int k = 0; k < 6; k++) begin
            v = 8'hB3 & 8'hC7 | {2'b00, STREAM[3 * k +: 3], 3'b000};
            check("framed tx byte", v, u_line.sent_q[k + 1]);
        end
        wr(ADDR_TX_CTRL, 8'h00);
    endtask : t_tx_framed
    task automatic t_rx_plain();
        u_line.idle_byte <= 8'hD6;
        wr(ADDR_RX_CFG, 8'h48);
        arm(ADDR_RX_CTRL, 8'h05);
        ticks(3);
        check("channel byte", 8'hD6, chan_rx_byte);
        wr(ADDR_RX_CTRL, 8'h01);
        drain();
        check("plain rx byte", 8'h94, got[0]);
    endtask : t_rx_plain
    // foreign bits around the field are set to show they are dropped
    task automatic t_rx_framed();
        u_line.idle_byte <= 8'h00;
        wr(ADDR_RX_CFG, 8'h1B);
        ticks(1);
        @(posedge clk_sys);
        for (int k = 0; k < 6; k++)
            u_line.feed_q.push_back(8'hC7 | {2'b00, STREAM[3 * k +: 3], 3'b000});
        arm(ADDR_RX_CTRL, 8'h04);
        ticks(8);
        wr(ADDR_RX_CTRL, 8'h01);
        drain();
        check("framed rx byte one", 8'hA5, got[0]);
        check("framed rx byte two", 8'h3C, got[1]);
    endtask : t_rx_framed
    initial begin
        sys_rst   = 1'b1;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        tx_data   = 8'h00;
        tx_valid  = 1'b0;
        rx_ready  = 1'b0;
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_tx_plain();
        t_tx_framed();
        t_rx_plain();
        t_rx_framed();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
